// [core/fapc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fapc_top #(
	parameter bit FLASH_SMALL = 1'b1,
	parameter int unsigned WINDOW_CYCLES = 32'(fapc_pkg::WINDOW_CYCLES),
	parameter int unsigned KEY_DELAY_CYCLES =
		32'(fapc_pkg::KEY_DELAY_CYCLES),
	parameter int unsigned PULSE_MIN_CYCLES =
		32'(fapc_pkg::PULSE_MIN_CYCLES),
	parameter int unsigned PULSE_MAX_CYCLES =
		32'(fapc_pkg::PULSE_MAX_CYCLES),
	parameter int unsigned UNLOCK_PULSES = fapc_pkg::UNLOCK_PULSES
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register bus
	input wire logic [15:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// command sequencer side
	input wire logic cmd_start,
	input wire logic [4:0] cmd_code,
	output logic cmd_fail,
	// flash array side
	output logic flash_go,
	output logic [4:0] flash_cmd,
	output logic [15:0] flash_addr,
	output logic flash_timing_tick,
	// protection
	input wire logic bus_receive_pin,
	output logic [7:0] sector_protect,
	output logic code_unlocked
);
	import fapc_pkg::*;

	logic [7:0] flash_addr_low;
	logic [7:0] flash_addr_high;
	logic [7:0] flash_timing_scaler;
	logic [7:0] sector_write_protect;
	logic [7:0] prot_mask;
	fapc_lock_type lock_state;
	logic [31:0] key_cnt;
	logic [31:0] win_cnt;
	logic window_open;
	logic pin_meta, pin_sync, pin_prev, pin_rise;
	logic [31:0] low_cnt;
	logic [31:0] pulse_cnt;
	logic pulse_good;
	logic pin_done;
	logic key_wr;
	logic key_good;
	logic key_bad;
	logic key_expire;
	logic cmd_modify;
	logic cmd_valid;

	fapc_tb_if tb_bus ();

	// true when an erase or write to addr must be refused
	function automatic logic modify_blocked(input logic [15:0] addr,
		input logic [7:0] prot, input logic unlocked);
		logic hit;
		hit = 1'b0;
		unique case (addr[15:12])
			4'hE: hit = !prot[7];
			4'hD: hit = !prot[6];
			4'h8, 4'h9, 4'hA, 4'hB, 4'hC: hit = !prot[5];
			4'h7: hit = 1'b1;
			4'h5, 4'h6: hit = !prot[3];
			4'h3, 4'h4: hit = !prot[2];
			4'h1, 4'h2: hit = !prot[1];
			4'h0: hit = !prot[0];
			4'hF: hit = 1'b1;
		endcase
		// code lock sits on top of the sector bits
		if (!unlocked && addr <= CODE_LOCK_HI) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : modify_blocked

	// recognised command codes
	function automatic logic code_known(input logic [4:0] code);
		return code == CMD_MAIN_READ || code == CMD_SECTOR_ERASE ||
			code == CMD_MAIN_WRITE || code == CMD_INFO_READ ||
			code == CMD_INFO_WRITE;
	endfunction : code_known

	// bus decode of the key register
	assign key_wr = sfr_wr && sfr_addr == OFS_CODE_KEY;
	assign key_good = key_wr && sfr_wdata == UNLOCK_KEY;
	assign key_bad = key_wr && sfr_wdata != UNLOCK_KEY;
	assign key_expire = lock_state == LK_KEY_WAIT &&
		key_cnt == KEY_DELAY_CYCLES - 32'd1;
	// small flash has no upper sectors, those bits stay 0
	assign prot_mask = FLASH_SMALL ? PROT_MASK_SMALL : PROT_RESET;

	// address bytes
	always_ff @(posedge clock) begin
		if (srst) begin
			flash_addr_low <= ADDR_RESET;
			flash_addr_high <= ADDR_RESET;
		end else if (sfr_wr) begin
			if (sfr_addr == OFS_ADDR_LOW) begin
				flash_addr_low <= sfr_wdata;
			end
			if (sfr_addr == OFS_ADDR_HIGH) begin
				flash_addr_high <= sfr_wdata;
			end
		end
	end

	// timing scaler setting
	always_ff @(posedge clock) begin
		if (srst) begin
			flash_timing_scaler <= SCALER_RESET;
		end else if (sfr_wr && sfr_addr == OFS_SCALER) begin
			flash_timing_scaler <= sfr_wdata;
		end
	end

	// protect bits only ever fall; a set needs a reset
	always_ff @(posedge clock) begin
		if (srst) begin
			sector_write_protect <= PROT_RESET & prot_mask;
		end else if (sfr_wr && sfr_addr == OFS_SECTOR_PROTECT) begin
			sector_write_protect <=
				sector_write_protect & sfr_wdata & prot_mask;
		end
	end

	// register read-back, one cycle after the strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			sfr_rdata <= READ_EMPTY;
		end else if (sfr_rd) begin
			unique case (sfr_addr)
				OFS_ADDR_LOW: sfr_rdata <= flash_addr_low;
				OFS_ADDR_HIGH: sfr_rdata <= flash_addr_high;
				OFS_SCALER: sfr_rdata <= flash_timing_scaler;
				OFS_SECTOR_PROTECT: sfr_rdata <= sector_write_protect;
				default: sfr_rdata <= READ_EMPTY; // key reads as zero
			endcase
		end
	end

	// pin unlock window open for a fixed time after reset
	always_ff @(posedge clock) begin
		if (srst) begin
			win_cnt <= 32'h0000_0000;
		end else if (window_open) begin
			win_cnt <= win_cnt + 32'd1;
		end
	end
	assign window_open = win_cnt < WINDOW_CYCLES;

	// pin synchroniser; only the second stage feeds logic
	always_ff @(posedge clock) begin
		if (srst) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_meta <= bus_receive_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	assign pin_rise = pin_sync && !pin_prev;

	// width of the current low pulse, saturating
	always_ff @(posedge clock) begin
		if (srst || pin_sync) begin
			low_cnt <= 32'h0000_0000;
		end else if (low_cnt != 32'hFFFF_FFFF) begin
			low_cnt <= low_cnt + 32'd1;
		end
	end
	assign pulse_good = low_cnt >= PULSE_MIN_CYCLES &&
		low_cnt <= PULSE_MAX_CYCLES;

	// run of in-spec low pulses; any stray pulse restarts it
	always_ff @(posedge clock) begin
		if (srst || !window_open) begin
			pulse_cnt <= 32'h0000_0000;
		end else if (pin_rise) begin
			pulse_cnt <= pulse_good ? pulse_cnt + 32'd1 : 32'h0000_0000;
		end
	end
	assign pin_done = window_open && pin_rise && pulse_good &&
		pulse_cnt == UNLOCK_PULSES - 32'd1;

	// lock state; a hardware release beats a same-cycle relock
	always_ff @(posedge clock) begin
		if (srst) begin
			lock_state <= LK_LOCKED;
		end else begin
			unique case (lock_state)
				LK_LOCKED: begin
					if (pin_done) begin
						lock_state <= LK_UNLOCKED;
					end else if (key_good) begin
						lock_state <= LK_KEY_WAIT;
					end
				end
				LK_KEY_WAIT: begin
					if (pin_done || key_expire) begin
						lock_state <= LK_UNLOCKED;
					end else if (key_bad) begin
						lock_state <= LK_LOCKED;
					end
				end
				LK_UNLOCKED: begin
					if (key_bad && !pin_done) begin
						lock_state <= LK_LOCKED;
					end
				end
			endcase
		end
	end

	// key delay; a repeated key restarts the wait
	always_ff @(posedge clock) begin
		if (srst || lock_state != LK_KEY_WAIT || key_good) begin
			key_cnt <= 32'h0000_0000;
		end else begin
			key_cnt <= key_cnt + 32'd1;
		end
	end
	assign code_unlocked = lock_state == LK_UNLOCKED;

	// command gate: array sees only commands that pass every check
	assign cmd_valid = code_known(cmd_code);
	assign cmd_modify = cmd_code == CMD_SECTOR_ERASE ||
		cmd_code == CMD_MAIN_WRITE;
	always_ff @(posedge clock) begin
		if (srst) begin
			flash_go <= 1'b0;
			cmd_fail <= 1'b0;
			flash_cmd <= 5'h00;
		end else begin
			flash_go <= 1'b0;
			cmd_fail <= 1'b0;
			if (cmd_start) begin
				if (!cmd_valid) begin
					cmd_fail <= 1'b1;
				end else if (cmd_modify && modify_blocked(flash_addr,
					sector_write_protect, code_unlocked)) begin
					cmd_fail <= 1'b1;
				end else begin
					flash_go <= 1'b1;
					flash_cmd <= cmd_code;
				end
			end
		end
	end

	// timing base generator
	assign tb_bus.scaler = flash_timing_scaler;
	fapc_timebase u_timebase (
		.clock(clock),
		.srst(srst),
		.tb(tb_bus)
	);
	assign flash_timing_tick = tb_bus.tick;
	assign flash_addr = {flash_addr_high, flash_addr_low};
	assign sector_protect = sector_write_protect;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_ADDR_LOW: assert property (sfr_wr &&
		sfr_addr == OFS_ADDR_LOW |=> flash_addr[7:0] == $past(sfr_wdata))
		else $error("low address byte not stored");
	AST_ADDR_HIGH: assert property (sfr_wr &&
		sfr_addr == OFS_ADDR_HIGH |=> flash_addr[15:8] == $past(sfr_wdata))
		else $error("high address byte not stored");
	AST_PROT_RESET: assert property ($past(srst) |->
		sector_write_protect == (PROT_RESET & prot_mask))
		else $error("protect bits wrong after reset");
	AST_PROT_NO_SET: assert property (!$past(srst) |->
		(sector_write_protect & ~$past(sector_write_protect)) == 8'h00)
		else $error("protect bit rose without reset");
	AST_SMALL_TIED: assert property (FLASH_SMALL |->
		sector_write_protect[7:4] == 4'h0)
		else $error("upper protect bits not tied low");
	AST_PROT_REFUSE: assert property (cmd_start && cmd_modify &&
		modify_blocked(flash_addr, sector_write_protect, code_unlocked)
		|=> cmd_fail && !flash_go)
		else $error("protected modify not refused");
	AST_BOOT_SAFE: assert property (cmd_start && cmd_modify &&
		flash_addr >= BOOT_LO && flash_addr <= BOOT_HI
		|=> cmd_fail && !flash_go)
		else $error("boot region modify allowed");
	AST_INVALID: assert property (cmd_start && !cmd_valid |=>
		cmd_fail && !flash_go)
		else $error("invalid command executed");
	AST_LOCK_RESET: assert property ($past(srst) |-> !code_unlocked)
		else $error("lock not on after reset");
	AST_KEY_WAIT: assert property (key_good && !code_unlocked &&
		!window_open |=> !code_unlocked [*8])
		else $error("key released lock too early");
	AST_KEY_RELEASE: assert property (key_expire |=> code_unlocked)
		else $error("key delay expired without release");
	AST_BAD_KEY: assert property (key_bad && !pin_done &&
		!key_expire |=> !code_unlocked)
		else $error("bad key did not relock");
	AST_PIN_RELEASE: assert property (pin_done |=> code_unlocked)
		else $error("pin sequence did not release lock");

	COV_KEY_UNLOCK: cover property (key_expire ##1 code_unlocked);
	COV_PIN_UNLOCK: cover property (pin_done ##1 code_unlocked);
	COV_REFUSED: cover property (cmd_start && cmd_modify ##1 cmd_fail);
	COV_WRITE_OK: cover property (cmd_start &&
		cmd_code == CMD_MAIN_WRITE ##1 flash_go);
endmodule : fapc_top
`default_nettype wire

// [include/fapc_pkg.sv]
package fapc_pkg;
	// register byte addresses on the special-function-register bus
	localparam logic [15:0] OFS_SECTOR_PROTECT = 16'hA012;
	localparam logic [15:0] OFS_CODE_KEY = 16'hA013;
	localparam logic [15:0] OFS_ADDR_HIGH = 16'hA022;
	localparam logic [15:0] OFS_ADDR_LOW = 16'hA023;
	localparam logic [15:0] OFS_SCALER = 16'hA024;

	// values after reset, the small-flash protect mask and the unlock key
	localparam logic [7:0] PROT_RESET = 8'hFF;
	localparam logic [7:0] PROT_MASK_SMALL = 8'h0F;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] SCALER_RESET = 8'h25;
	localparam logic [7:0] READ_EMPTY = 8'h00;
	localparam logic [7:0] UNLOCK_KEY = 8'h55;

	// flash command codes
	localparam logic [4:0] CMD_MAIN_READ = 5'h10;
	localparam logic [4:0] CMD_SECTOR_ERASE = 5'h08;
	localparam logic [4:0] CMD_MAIN_WRITE = 5'h04;
	localparam logic [4:0] CMD_INFO_READ = 5'h02;
	localparam logic [4:0] CMD_INFO_WRITE = 5'h01;

	// address regions
	localparam logic [15:0] BOOT_LO = 16'h7000;
	localparam logic [15:0] BOOT_HI = 16'h7FFF;
	localparam logic [15:0] CODE_LOCK_HI = 16'h6FFF;

	// timing
	localparam longint CLK_HZ = 250_000_000;
	localparam longint UNLOCK_WINDOW_S = 5;
	localparam longint KEY_DELAY_S = 1;
	localparam longint PULSE_MIN_US = 10;
	localparam longint PULSE_MAX_US = 20;
	localparam int UNLOCK_PULSES = 8;
	localparam longint WINDOW_CYCLES = CLK_HZ * UNLOCK_WINDOW_S;
	localparam longint KEY_DELAY_CYCLES = CLK_HZ * KEY_DELAY_S;
	localparam longint PULSE_MIN_CYCLES =
		(CLK_HZ * PULSE_MIN_US + 64'd999_999) / 64'd1_000_000;
	localparam longint PULSE_MAX_CYCLES =
		(CLK_HZ * PULSE_MAX_US) / 64'd1_000_000;

	// code-protection lock states
	typedef enum logic [1:0] {
		LK_LOCKED,
		LK_KEY_WAIT,
		LK_UNLOCKED
	} fapc_lock_type;
endpackage : fapc_pkg

// [include/fapc_tb_if.sv]
`timescale 1ns/1ps
`default_nettype none
// scaler setting out, timing tick back
interface fapc_tb_if;
	logic [7:0] scaler;
	logic tick;
	modport ctrl (output scaler, input tick);
	modport gen (input scaler, output tick);
endinterface : fapc_tb_if
`default_nettype wire

// [core/fapc_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
module fapc_timebase (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// scaler in, tick out
	fapc_tb_if.gen tb
);
	import fapc_pkg::*;

	logic [7:0] phase;
	logic [8:0] next_phase;

	// phase step of scaler+1 out of 256; carry is the tick
	always_comb begin
		next_phase = {1'b0, phase} + {1'b0, tb.scaler} + 9'h001;
	end

	// accumulator keeps the remainder so the mean rate is exact
	always_ff @(posedge clock) begin
		if (srst) begin
			phase <= ADDR_RESET;
			tb.tick <= 1'b0;
		end else begin
			phase <= next_phase[7:0];
			tb.tick <= next_phase[8];
		end
	end

	AST_TICK_FULL: assert property (@(posedge clock)
		disable iff (srst) (tb.scaler == 8'hFF) [*2] |-> tb.tick)
		else $error("tick missing at full scaler");
	// the tick must come from a step of 1 at scaler 0, so the phase is known to be 0
	AST_TICK_SLOW: assert property (@(posedge clock)
		disable iff (srst) (tb.scaler == 8'h00)
		##1 (tb.tick && tb.scaler == 8'h00) ##1 (tb.scaler == 8'h00) [*8]
		|-> $past(tb.tick, 8) && !$past(tb.tick, 1))
		else $error("tick too fast at minimum scaler");
endmodule : fapc_timebase
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fapc_pkg::*;
	localparam int KD = 40;
	logic clock, srst, sfr_wr, sfr_rd, cmd_start, bus_receive_pin;
	logic [15:0] sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata, sector_protect, prot_m;
	logic [4:0] cmd_code, flash_cmd;
	logic cmd_fail, flash_go, flash_timing_tick, code_unlocked, unl_m;
	logic [15:0] flash_addr;
	logic [31:0] seed = 32'h94CDD346;
	int err_total, num_checks;
	logic [15:0] corner [5] = '{16'h7000, 16'h7FFF, 16'h0FFF, 16'h6FFF,
		16'hF000};
	logic [4:0] codes [8] = '{CMD_MAIN_READ, CMD_SECTOR_ERASE, CMD_MAIN_WRITE,
		CMD_INFO_READ, CMD_INFO_WRITE, 5'h03, 5'h12, 5'h00};

	// short counts keep the key delay and pin window inside the run
	fapc_top #(.FLASH_SMALL(1'b1), .WINDOW_CYCLES(150),
		.KEY_DELAY_CYCLES(KD), .PULSE_MIN_CYCLES(4), .PULSE_MAX_CYCLES(8),
		.UNLOCK_PULSES(3)) dut (.clock(clock), .srst(srst),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_fail(cmd_fail),
		.flash_go(flash_go), .flash_cmd(flash_cmd), .flash_addr(flash_addr),
		.flash_timing_tick(flash_timing_tick),
		.bus_receive_pin(bus_receive_pin),
		.sector_protect(sector_protect), .code_unlocked(code_unlocked));

	// free-running system clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// fixed-seed lfsr so failures repeat
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// refusal model: modify commands only are range checked
	function logic exp_fail(logic [4:0] c, logic [15:0] a, logic [7:0] p,
		logic u);
		int b;
		if (!(c inside {CMD_MAIN_READ, CMD_SECTOR_ERASE, CMD_MAIN_WRITE,
			CMD_INFO_READ, CMD_INFO_WRITE}))
			return 1'b1;
		if (c != CMD_SECTOR_ERASE && c != CMD_MAIN_WRITE)
			return 1'b0;
		if ((a >= BOOT_LO && a <= BOOT_HI) || a >= 16'hF000)
			return 1'b1;
		if (a <= CODE_LOCK_HI && !u)
			return 1'b1;
		b = a >= 16'hE000 ? 7 : a >= 16'hD000 ? 6 : a >= 16'h8000 ? 5 :
			a >= 16'h7000 ? 4 : a >= 16'h5000 ? 3 : a >= 16'h3000 ? 2 :
			a >= 16'h1000 ? 1 : 0;
		return !p[b];
	endfunction : exp_fail

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task summarize();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// one-cycle write strobe, returns just after the taking edge
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		@(posedge clock);
		#1;
		chk(16'(sfr_rdata), 16'(e));
	endtask : rd

	task waitu(input logic v, input int lim);
		for (int i = 0; i < lim && code_unlocked !== v; i++)
			@(posedge clock) #1;
		chk(16'(code_unlocked), 16'(v));
	endtask : waitu

	task cmd(input logic [4:0] c, input logic [15:0] a);
		logic e;
		e = exp_fail(c, a, prot_m, unl_m);
		wr(OFS_ADDR_HIGH, a[15:8]);
		wr(OFS_ADDR_LOW, a[7:0]);
		chk(flash_addr, a);
		@(posedge clock);
		cmd_start <= 1'b1;
		cmd_code <= c;
		@(posedge clock);
		cmd_start <= 1'b0;
		// answer pulses stand for one cycle only
		#1;
		chk(16'(cmd_fail), 16'(e));
		chk(16'(flash_go), 16'(!e));
		if (!e)
			chk(16'(flash_cmd), 16'(c));
	endtask : cmd

	// random commands with corner addresses first, protect cleared at random
	task run_cmds(input int n);
		logic [31:0] r, v;
		for (int i = 0; i < n; i++) begin
			r = rnd();
			if (r[6:4] == 3'h0) begin
				v = rnd();
				wr(OFS_SECTOR_PROTECT, v[7:0]);
				prot_m = prot_m & v[7:0];
				chk(16'(sector_protect), 16'(prot_m));
			end
			cmd(codes[r[2:0]], i < 5 ? corner[i] : r[31:16]);
		end
	endtask : run_cmds

	task do_reset();
		@(posedge clock);
		srst <= 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		#1;
		prot_m = 8'h0F;
		unl_m = 1'b0;
	endtask : do_reset

	task pulse(input int w);
		@(posedge clock);
		bus_receive_pin <= 1'b0;
		repeat (w) @(posedge clock);
		bus_receive_pin <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
	endtask : pulse

	// tick count over ten periods of 256 clocks
	task tick(input logic [7:0] s);
		int n;
		n = 0;
		wr(OFS_SCALER, s);
		rd(OFS_SCALER, s);
		repeat (2560) begin
			@(posedge clock);
			#1;
			if (flash_timing_tick === 1'b1)
				n++;
		end
		n = n - (s + 1) * 10;
		chk(16'(n > 1 || n < -1), 16'h0000);
	endtask : tick

	// watchdog cuts a hang short
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		summarize();
	end

	// main sequence
	initial begin
		{srst, sfr_wr, sfr_rd, cmd_start} = 4'h0;
		bus_receive_pin = 1'b1;
		sfr_addr = 16'h0000;
		sfr_wdata = 8'h00;
		cmd_code = 5'h00;
		err_total = 0;
		num_checks = 0;
		do_reset();
		chk(16'(code_unlocked), 16'h0000);
		rd(OFS_SECTOR_PROTECT, 8'h0F);
		rd(OFS_ADDR_LOW, ADDR_RESET);
		rd(OFS_SCALER, SCALER_RESET);
		rd(OFS_CODE_KEY, READ_EMPTY);
		// an over-long pulse must restart the run
		pulse(6);
		pulse(12);
		pulse(6);
		pulse(6);
		chk(16'(code_unlocked), 16'h0000);
		pulse(6);
		waitu(1'b1, 1);
		unl_m = 1'b1;
		run_cmds(24);
		wr(16'hA014, 8'hAA);
		rd(16'hA014, READ_EMPTY);
		wr(OFS_CODE_KEY, 8'h12);
		waitu(1'b0, 2);
		unl_m = 1'b0;
		// pin train after the window has closed must not unlock
		repeat (3) pulse(6);
		chk(16'(code_unlocked), 16'h0000);
		wr(OFS_CODE_KEY, UNLOCK_KEY);
		repeat (KD - 1) @(posedge clock);
		#1;
		chk(16'(code_unlocked), 16'h0000);
		waitu(1'b1, 1);
		unl_m = 1'b1;
		wr(OFS_SECTOR_PROTECT, 8'hFF);
		rd(OFS_SECTOR_PROTECT, prot_m);
		run_cmds(24);
		wr(OFS_CODE_KEY, 8'h00);
		waitu(1'b0, 2);
		unl_m = 1'b0;
		run_cmds(12);
		tick(8'(rnd() >> 24));
		tick(8'hFF);
		// scaler for a timing tick near 2 MHz
		tick(8'(512_000_000 / CLK_HZ - 1));
		tick(8'h00);
		do_reset();
		rd(OFS_SECTOR_PROTECT, 8'h0F);
		chk(16'(code_unlocked), 16'h0000);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
